// [logic/optmod_params.svh]
// Timing constants and register map of the optical module control block
// Behaviour
// - Laser output goes off within 100 us of disable rising.
// - In normal running, laser returns within 2 ms of disable falling.
// - Management interface ready within 300 ms of supply valid.
// - Non-cooled part fully operational within 300 ms of start-up trigger.
// - Cooled part fully operational within 90 s of start-up trigger.
// - Entering power level II completes within 300 ms of the write.
// - Leaving power level II completes within 300 ms of the write.
// - Non-cooled part raises fault flag within 1 ms of a fault.
// - Cooled part raises fault flag within 50 ms of a fault.
// - Disable held high at least 10 us clears a latched fault.
// - Fibre Channel rate select settles within 500 us.
// - Other rate select settles within 10 ms.
// - Loss flag rises within 100 us of signal loss.
// - Loss flag falls within 100 us of signal return.
`ifndef OPTMOD_PARAMS_SVH
`define OPTMOD_PARAMS_SVH

// Clock rate and safety margin divider on every upper bound
`define OPT_CLK_MHZ 100
`define OPT_MARGIN_DIV 2

// Interval bounds in microseconds
`define OPT_T_2W_US 300000
`define OPT_T_START_US 300000
`define OPT_T_START_COOLED_US 90000000
`define OPT_T_PL2_US 300000
`define OPT_T_FAULT_US 1000
`define OPT_T_FAULT_COOLED_US 50000
`define OPT_T_RESET_US 10
`define OPT_T_RS_FC_US 500
`define OPT_T_RS_US 10000
`define OPT_T_LOS_US 100

// Register byte offsets
`define OPT_ADR_CTRL 8'h00
`define OPT_ADR_STATUS 8'h04
`define OPT_ADR_IRQ_STAT 8'h08
`define OPT_ADR_IRQ_MASK 8'h0C

// Control field positions and reset value
`define OPT_CTRL_COOLED 0
`define OPT_CTRL_FC 1
`define OPT_CTRL_PL2 2
`define OPT_CTRL_RST 3'h0

// Interrupt bit positions and mask reset value
`define OPT_IRQ_FAULT 0
`define OPT_IRQ_LOS_ON 1
`define OPT_IRQ_LOS_OFF 2
`define OPT_IRQ_OPER 3
`define OPT_IRQ_MGMT 4
`define OPT_IRQ_MASK_RST 5'h00

`endif

// [logic/optmod_pkg.sv]
// Types shared by the optical module control logic
package optmod_pkg;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_INIT = 2'b01,
      ST_RUN = 2'b10,
      ST_FAULT = 2'b11
   } pwr_state_e;
endpackage

// [logic/interval_timer.sv]
// Saturating microsecond interval timer with a one-cycle expiry pulse
`timescale 1ns/1ps
module interval_timer #(
   parameter int W = 27
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Count control
   input wire logic clear_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic [W-1:0] limit_i,
   // Expiry
   output logic done_o
);
   logic [W-1:0] cnt_ff;

   // Step on each tick while running; pulse on reaching the limit, and on the
   // next tick when the limit is lowered below the count, so no wait on a nonzero limit can hang
   wire step = run_i && tick_i && (cnt_ff < limit_i);
   wire hit = run_i && tick_i && (cnt_ff >= limit_i - W'(1));

   // Count up to the limit and hold there until cleared
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         cnt_ff <= '0;
         done_o <= 1'b0;
      end else begin
         if (step) begin
            cnt_ff <= cnt_ff + W'(1);
         end
         done_o <= hit;
      end
   end
endmodule

// [logic/optmod_ctrl.sv]
// Control and status timing core of the pluggable optical module
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "optmod_params.svh"
module optmod_ctrl #(
   parameter int CLK_MHZ = `OPT_CLK_MHZ,
   parameter int TW = 27,
   parameter int T_2W_US = `OPT_T_2W_US,
   parameter int T_START_US = `OPT_T_START_US,
   parameter int T_START_COOLED_US = `OPT_T_START_COOLED_US,
   parameter int T_PL2_US = `OPT_T_PL2_US,
   parameter int T_FAULT_US = `OPT_T_FAULT_US,
   parameter int T_FAULT_COOLED_US = `OPT_T_FAULT_COOLED_US,
   parameter int T_RESET_US = `OPT_T_RESET_US,
   parameter int T_RS_FC_US = `OPT_T_RS_FC_US,
   parameter int T_RS_US = `OPT_T_RS_US,
   parameter int T_LOS_US = `OPT_T_LOS_US
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Module pins and front end
   input wire logic power_good_i,
   input wire logic tx_disable_i,
   input wire logic rs0_i,
   input wire logic rs1_i,
   input wire logic laser_fault_i,
   input wire logic sig_present_i,
   output logic laser_en_o,
   output logic tx_fault_o,
   output logic rx_los_o,
   // Status
   output logic mgmt_ready_o,
   output logic op_ready_o,
   output logic rate_stable_o,
   output logic pl2_active_o,
   output logic irq_o
);
   localparam int NT = 7;
   localparam int T2W = 0;
   localparam int TST = 1;
   localparam int TFL = 2;
   localparam int THD = 3;
   localparam int TRS = 4;
   localparam int TPL = 5;
   localparam int TLS = 6;

   optmod_pkg::pwr_state_e state_ff;
   optmod_pkg::pwr_state_e nxt_state;
   logic [7:0] div_ff;
   logic tick_ff;
   logic [2:0] ctrl_ff;
   logic [4:0] irq_stat_ff;
   logic [4:0] irq_mask_ff;
   logic laser_ff;
   logic fault_ff;
   logic los_ff;
   logic mgmt_ff;
   logic op_ff;
   logic rate_ok_ff;
   logic pl2_ff;
   logic hold_met_ff;
   logic irq_ff;
   logic [1:0] rs_prev_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic [NT-1:0] t_run;
   logic [NT-1:0] t_done;
   logic [TW-1:0] t_lim [NT];

   // Microsecond tick divider
   wire div_end = (div_ff == 8'(CLK_MHZ - 1));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         div_ff <= div_end ? '0 : div_ff + 8'h01;
         tick_ff <= div_end;
      end
   end

   // Control fields and derived conditions
   wire cooled = ctrl_ff[`OPT_CTRL_COOLED];
   wire fc_mode = ctrl_ff[`OPT_CTRL_FC];
   wire pl2_req = ctrl_ff[`OPT_CTRL_PL2];
   wire st_init = (state_ff == optmod_pkg::ST_INIT);
   wire st_run = (state_ff == optmod_pkg::ST_RUN);
   wire active = st_init || st_run;
   wire pl2_busy = (pl2_ff != pl2_req);
   wire los_raw = !sig_present_i;
   wire los_diff = (los_raw != los_ff);
   wire rs_chg = ({rs1_i, rs0_i} != rs_prev_ff);

   // Run conditions of the interval timers
   assign t_run[T2W] = power_good_i && !mgmt_ff;
   assign t_run[TST] = st_init && !tx_disable_i;
   assign t_run[TFL] = active && laser_fault_i;
   assign t_run[THD] = tx_disable_i;
   assign t_run[TRS] = !rate_ok_ff && !rs_chg;
   assign t_run[TPL] = pl2_busy;
   assign t_run[TLS] = los_diff;

   // Terminal counts, upper bounds shortened by the margin divider
   assign t_lim[T2W] = TW'(T_2W_US / `OPT_MARGIN_DIV);
   assign t_lim[TST] = cooled ? TW'(T_START_COOLED_US / `OPT_MARGIN_DIV)
                              : TW'(T_START_US / `OPT_MARGIN_DIV);
   assign t_lim[TFL] = cooled ? TW'(T_FAULT_COOLED_US / `OPT_MARGIN_DIV)
                              : TW'(T_FAULT_US / `OPT_MARGIN_DIV);
   assign t_lim[THD] = TW'(T_RESET_US - 1);
   assign t_lim[TRS] = fc_mode ? TW'(T_RS_FC_US / `OPT_MARGIN_DIV)
                               : TW'(T_RS_US / `OPT_MARGIN_DIV);
   assign t_lim[TPL] = TW'(T_PL2_US / `OPT_MARGIN_DIV);
   assign t_lim[TLS] = TW'(T_LOS_US / `OPT_MARGIN_DIV);

   // One interval timer per timed condition, restarted on expiry
   genvar gi;
   for (gi = 0; gi < NT; gi++) begin : g_tmr
      interval_timer #(.W(TW)) u_tmr (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .clear_i(!t_run[gi] || t_done[gi]),
         .run_i(t_run[gi]),
         .tick_i(tick_ff),
         .limit_i(t_lim[gi]),
         .done_o(t_done[gi])
      );
   end

   // Power and fault sequencer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         optmod_pkg::ST_OFF: begin
            if (power_good_i) begin
               nxt_state = optmod_pkg::ST_INIT;
            end
         end
         optmod_pkg::ST_INIT: begin
            if (!power_good_i) begin
               nxt_state = optmod_pkg::ST_OFF;
            end else if (t_done[TFL]) begin
               nxt_state = optmod_pkg::ST_FAULT;
            end else if (t_done[TST]) begin
               nxt_state = optmod_pkg::ST_RUN;
            end
         end
         optmod_pkg::ST_RUN: begin
            if (!power_good_i) begin
               nxt_state = optmod_pkg::ST_OFF;
            end else if (t_done[TFL]) begin
               nxt_state = optmod_pkg::ST_FAULT;
            end
         end
         optmod_pkg::ST_FAULT: begin
            if (!power_good_i) begin
               nxt_state = optmod_pkg::ST_OFF;
            end else if (hold_met_ff && !tx_disable_i) begin
               nxt_state = optmod_pkg::ST_INIT;
            end
         end
      endcase
   end

   // Next values of the status flops
   wire nxt_run = (nxt_state == optmod_pkg::ST_RUN);
   wire nxt_laser = ((nxt_state == optmod_pkg::ST_INIT) || nxt_run) && !tx_disable_i;
   wire nxt_fault = (nxt_state == optmod_pkg::ST_FAULT);
   wire nxt_mgmt = power_good_i && (mgmt_ff || t_done[T2W]);
   wire nxt_op = st_run && !pl2_busy;
   wire nxt_los = t_done[TLS] ? !los_ff : los_ff;

   // Status flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= optmod_pkg::ST_OFF;
         laser_ff <= 1'b0;
         fault_ff <= 1'b0;
         los_ff <= 1'b1;
         mgmt_ff <= 1'b0;
         op_ff <= 1'b0;
         rate_ok_ff <= 1'b0;
         pl2_ff <= 1'b0;
         hold_met_ff <= 1'b0;
         rs_prev_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         laser_ff <= nxt_laser;
         fault_ff <= nxt_fault;
         los_ff <= nxt_los;
         mgmt_ff <= nxt_mgmt;
         op_ff <= nxt_op;
         rate_ok_ff <= !rs_chg && (rate_ok_ff || t_done[TRS]);
         pl2_ff <= t_done[TPL] ? pl2_req : pl2_ff;
         hold_met_ff <= tx_disable_i && (hold_met_ff || t_done[THD]);
         rs_prev_ff <= {rs1_i, rs0_i};
      end
   end

   // Interrupt events, taken from the flop updates
   wire [4:0] irq_evt = {nxt_mgmt && !mgmt_ff,
                         nxt_op && !op_ff,
                         t_done[TLS] && los_ff,
                         t_done[TLS] && !los_ff,
                         nxt_fault && !fault_ff};

   // Wishbone decode; writes land on the edge that samples ack
   wire bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
   wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];
   wire sel_ctrl = (wb_adr_i == `OPT_ADR_CTRL);
   wire sel_stat = (wb_adr_i == `OPT_ADR_STATUS);
   wire sel_istat = (wb_adr_i == `OPT_ADR_IRQ_STAT);
   wire sel_imask = (wb_adr_i == `OPT_ADR_IRQ_MASK);
   wire [4:0] w1c = (bus_wr && sel_istat) ? wb_dat_i[4:0] : 5'h00;
   wire [8:0] status = {state_ff, pl2_ff, rate_ok_ff, laser_ff, los_ff, fault_ff,
                        op_ff, mgmt_ff};
   wire [31:0] rd_mux = sel_ctrl ? {29'h0, ctrl_ff} :
                        sel_stat ? {23'h0, status} :
                        sel_istat ? {27'h0, irq_stat_ff} :
                        sel_imask ? {27'h0, irq_mask_ff} : 32'h0000_0000;

   // Register file, interrupt status and bus answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= `OPT_CTRL_RST;
         irq_mask_ff <= `OPT_IRQ_MASK_RST;
         irq_stat_ff <= 5'h00;
         irq_ff <= 1'b0;
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         if (bus_wr && sel_ctrl) begin
            ctrl_ff <= wb_dat_i[2:0];
         end
         if (bus_wr && sel_imask) begin
            irq_mask_ff <= wb_dat_i[4:0];
         end
         irq_stat_ff <= (irq_stat_ff & ~w1c) | irq_evt; // Set wins over clear
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
         ack_ff <= bus_req;
         dat_ff <= bus_req ? rd_mux : 32'h0000_0000;
      end
   end

   // Outputs straight from flops
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign laser_en_o = laser_ff;
   assign tx_fault_o = fault_ff;
   assign rx_los_o = los_ff;
   assign mgmt_ready_o = mgmt_ff;
   assign op_ready_o = op_ff;
   assign rate_stable_o = rate_ok_ff;
   assign pl2_active_o = pl2_ff;
   assign irq_o = irq_ff;

   // Elapsed microseconds of each pending condition except the disable hold, for the checks below
   logic [TW-1:0] w2_us_ff;
   logic [TW-1:0] st_us_ff;
   logic [TW-1:0] fl_us_ff;
   logic [TW-1:0] pl_us_ff;
   logic [TW-1:0] rs_us_ff;
   logic [TW-1:0] ls_us_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         w2_us_ff <= '0;
         st_us_ff <= '0;
         fl_us_ff <= '0;
         pl_us_ff <= '0;
         rs_us_ff <= '0;
         ls_us_ff <= '0;
      end else begin
         w2_us_ff <= (power_good_i && !mgmt_ff) ? w2_us_ff + TW'(tick_ff) : '0;
         st_us_ff <= (st_init && !tx_disable_i) ? st_us_ff + TW'(tick_ff) : '0;
         fl_us_ff <= (active && laser_fault_i) ? fl_us_ff + TW'(tick_ff) : '0;
         pl_us_ff <= pl2_busy ? pl_us_ff + TW'(tick_ff) : '0;
         rs_us_ff <= (!rate_ok_ff && !rs_chg) ? rs_us_ff + TW'(tick_ff) : '0;
         ls_us_ff <= los_diff ? ls_us_ff + TW'(tick_ff) : '0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   laser_off_a: assert property ($rose(tx_disable_i) |=> !laser_en_o)
      else $error("Laser still on after disable rose");
   laser_on_a: assert property ($fell(tx_disable_i) && st_run && power_good_i
         && !t_done[TFL] |=> laser_en_o)
      else $error("Laser not back after disable fell");
   mgmt_bound_a: assert property (w2_us_ff <= TW'(T_2W_US))
      else $error("Management interface late");
   start_bound_a: assert property (!cooled |-> st_us_ff <= TW'(T_START_US))
      else $error("Start-up late");
   start_cool_a: assert property (cooled |-> st_us_ff <= TW'(T_START_COOLED_US))
      else $error("Cooled start-up late");
   pl2_up_a: assert property (pl2_req |-> pl_us_ff <= TW'(T_PL2_US))
      else $error("Power level II entry late");
   pl2_down_a: assert property (!pl2_req |-> pl_us_ff <= TW'(T_PL2_US))
      else $error("Power level II exit late");
   fault_on_a: assert property (!cooled |-> fl_us_ff <= TW'(T_FAULT_US))
      else $error("Fault flag late");
   fault_cool_a: assert property (cooled |-> fl_us_ff <= TW'(T_FAULT_COOLED_US))
      else $error("Cooled fault flag late");
   fault_clear_a: assert property ($fell(tx_fault_o) |->
         $past(hold_met_ff) || !$past(power_good_i))
      else $error("Fault cleared without disable hold");
   rate_fc_a: assert property (fc_mode |-> rs_us_ff <= TW'(T_RS_FC_US))
      else $error("FC rate select late");
   rate_std_a: assert property (!fc_mode |-> rs_us_ff <= TW'(T_RS_US))
      else $error("Rate select late");
   los_on_a: assert property (los_raw && !rx_los_o |-> ls_us_ff <= TW'(T_LOS_US))
      else $error("Loss flag rise late");
   los_off_a: assert property (!los_raw && rx_los_o |-> ls_us_ff <= TW'(T_LOS_US))
      else $error("Loss flag fall late");
endmodule

// [tb/host_model.sv]
// Host board controller model driving the disable and rate select pins
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic clk_i,
   // Control pins towards the module
   output logic tx_disable_o,
   output logic rs0_o,
   output logic rs1_o
);
   // Disable starts high, as the pull-up leaves an undriven pin
   initial begin
      tx_disable_o = 1'b1;
      rs0_o = 1'b0;
      rs1_o = 1'b0;
   end
   // Drive disable to a level just after the next edge
   task set_disable(input logic v);
      @(posedge clk_i);
      tx_disable_o <= v;
   endtask
   // Hold disable high for n cycles, then release it
   task hold_disable(input int n);
      @(posedge clk_i);
      tx_disable_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      tx_disable_o <= 1'b0;
   endtask
   // Change both rate select pins together
   task select_rate(input logic r0, input logic r1);
      @(posedge clk_i);
      rs0_o <= r0;
      rs1_o <= r1;
   endtask
endmodule

// [tb/optical_module_ctrl_status_timing_test.sv]
// Self-checking bench for the optical module control timing core
`timescale 1ns/1ps
`include "optmod_params.svh"
module optical_module_ctrl_status_timing_test;
   // Shortened interval bounds in microseconds, tick every MHZ cycles
   localparam int MHZ = 4;
   localparam int T2W = 40;
   localparam int TST = 40;
   localparam int TSC = 80;
   localparam int TPL = 40;
   localparam int TF = 20;
   localparam int TFC = 40;
   localparam int TRS = 4;
   localparam int TRF = 20;
   localparam int TRN = 40;
   localparam int TLS = 20;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o, rdata;
   logic wb_ack_o, laser_en_o, tx_fault_o, rx_los_o, mgmt_ready_o, op_ready_o;
   logic rate_stable_o, pl2_active_o, irq_o, tx_disable, rs0, rs1;
   logic power_good_i = 1'b0;
   logic laser_fault_i = 1'b0;
   logic sig_present_i = 1'b0;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   // Clock at 100 MHz
   always #5 clk_i = ~clk_i;
   optmod_ctrl #(.CLK_MHZ(MHZ), .T_2W_US(T2W), .T_START_US(TST), .T_START_COOLED_US(TSC),
      .T_PL2_US(TPL), .T_FAULT_US(TF), .T_FAULT_COOLED_US(TFC), .T_RESET_US(TRS),
      .T_RS_FC_US(TRF), .T_RS_US(TRN), .T_LOS_US(TLS)) optmod_ctrl_i (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .power_good_i(power_good_i), .tx_disable_i(tx_disable),
      .rs0_i(rs0), .rs1_i(rs1), .laser_fault_i(laser_fault_i), .sig_present_i(sig_present_i),
      .laser_en_o(laser_en_o), .tx_fault_o(tx_fault_o), .rx_los_o(rx_los_o),
      .mgmt_ready_o(mgmt_ready_o), .op_ready_o(op_ready_o), .rate_stable_o(rate_stable_o),
      .pl2_active_o(pl2_active_o), .irq_o(irq_o));
   host_model host_model_i (.clk_i(clk_i), .tx_disable_o(tx_disable), .rs0_o(rs0), .rs1_o(rs1));
   // Flag selector: 0 laser 1 fault 2 los 3 mgmt 4 oper 5 rate 6 pl2 7 irq 8 ack
   function automatic logic sig(input int k);
      case (k)
         0: sig = laser_en_o;
         1: sig = tx_fault_o;
         2: sig = rx_los_o;
         3: sig = mgmt_ready_o;
         4: sig = op_ready_o;
         5: sig = rate_stable_o;
         6: sig = pl2_active_o;
         7: sig = irq_o;
         default: sig = wb_ack_o;
      endcase
   endfunction
   // Verdict and end of run
   task conclude;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Compare one flag
   task chk_bit(input int k, input logic g, input logic e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t: flag %0d got %b expected %b", $time, k, g, e);
      end
   endtask
   // Compare one register word
   task chk_word(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t: word got %h expected %h", $time, g, e);
      end
   endtask
   // Wait a bounded number of cycles for a flag to reach a level
   task wait_sig(input int k, input logic v, input int lim);
      int n;
      n = 0;
      while (sig(k) !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      chk_bit(k, sig(k), v);
   endtask
   // One classic Wishbone cycle, read data lands in rdata
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      chk_bit(8, wb_ack_o, 1'b1);
      chk_bit(8, n == 2, 1'b1);
      rdata = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   // Reset values, read-only status and an unmapped place
   task t_reset;
      chk_bit(2, rx_los_o, 1'b1);
      chk_bit(0, laser_en_o, 1'b0);
      wb(1'b0, `OPT_ADR_CTRL, 32'h0000_0000);
      chk_word(rdata, 32'h0000_0000);
      wb(1'b0, `OPT_ADR_IRQ_MASK, 32'h0000_0000);
      chk_word(rdata, 32'h0000_0000);
      wb(1'b1, 8'h20, 32'hffff_ffff);
      wb(1'b0, 8'h20, 32'h0000_0000);
      chk_word(rdata, 32'h0000_0000);
      wb(1'b1, `OPT_ADR_STATUS, 32'hffff_ffff);
      wb(1'b0, `OPT_ADR_STATUS, 32'h0000_0000);
      chk_word(rdata, 32'h0000_0008);
   endtask
   // Power up, release disable, then signal arrives
   task t_startup;
      @(posedge clk_i);
      power_good_i <= 1'b1;
      wait_sig(3, 1'b1, T2W * MHZ);
      host_model_i.set_disable(1'b0);
      wait_sig(4, 1'b1, TST * MHZ);
      wait_sig(0, 1'b1, 8);
      sig_present_i <= 1'b1;
      wait_sig(2, 1'b0, TLS * MHZ);
      wb(1'b0, `OPT_ADR_STATUS, 32'h0000_0000);
      chk_word(rdata & 32'h0000_0180, 32'h0000_0100);
   endtask
   // Disable toggled in normal running
   task t_disable;
      host_model_i.set_disable(1'b1);
      wait_sig(0, 1'b0, 4);
      host_model_i.set_disable(1'b0);
      wait_sig(0, 1'b1, 8);
   endtask
   // Loss of signal with its interrupt masked in, then return with its interrupt masked out
   task t_los_irq;
      wb(1'b1, `OPT_ADR_IRQ_STAT, 32'h0000_001f);
      wb(1'b1, `OPT_ADR_IRQ_MASK, 32'h0000_0002);
      sig_present_i <= 1'b0;
      wait_sig(2, 1'b1, TLS * MHZ);
      wait_sig(7, 1'b1, 4);
      wb(1'b1, `OPT_ADR_IRQ_STAT, 32'h0000_0002);
      wait_sig(7, 1'b0, 4);
      sig_present_i <= 1'b1;
      wait_sig(2, 1'b0, TLS * MHZ);
      repeat (4) @(posedge clk_i);
      chk_bit(7, irq_o, 1'b0);
      wb(1'b0, `OPT_ADR_IRQ_STAT, 32'h0000_0000);
      chk_word(rdata & 32'h0000_0006, 32'h0000_0004);
      wb(1'b1, `OPT_ADR_IRQ_MASK, 32'h0000_0000);
   endtask
   // Rate select settling in both modes
   task t_rate;
      wb(1'b1, `OPT_ADR_CTRL, 32'h0000_0002);
      host_model_i.select_rate(1'b1, 1'b0);
      wait_sig(5, 1'b0, 4);
      wait_sig(5, 1'b1, TRF * MHZ);
      wb(1'b1, `OPT_ADR_CTRL, 32'h0000_0000);
      host_model_i.select_rate(1'b1, 1'b1);
      wait_sig(5, 1'b0, 4);
      wait_sig(5, 1'b1, TRN * MHZ);
   endtask
   // Power level II entry and exit
   task t_pl2;
      wb(1'b1, `OPT_ADR_CTRL, 32'h0000_0004);
      wait_sig(6, 1'b1, TPL * MHZ);
      wait_sig(4, 1'b1, TPL * MHZ);
      wb(1'b1, `OPT_ADR_CTRL, 32'h0000_0000);
      wait_sig(6, 1'b0, TPL * MHZ);
   endtask
   // Fault raise, a too short reset pulse, a proper reset, recovery
   task t_fault(input logic cooled);
      wb(1'b1, `OPT_ADR_CTRL, {31'h0000_0000, cooled});
      wb(1'b1, `OPT_ADR_IRQ_STAT, 32'h0000_001f);
      laser_fault_i <= 1'b1;
      wait_sig(1, 1'b1, (cooled ? TFC : TF) * MHZ);
      wait_sig(0, 1'b0, 4);
      laser_fault_i <= 1'b0;
      host_model_i.hold_disable(1);
      repeat (8) @(posedge clk_i);
      chk_bit(1, tx_fault_o, 1'b1);
      host_model_i.hold_disable(TRS * MHZ);
      wait_sig(1, 1'b0, 8);
      wait_sig(4, 1'b1, (cooled ? TSC : TST) * MHZ);
      wb(1'b0, `OPT_ADR_IRQ_STAT, 32'h0000_0000);
      chk_word(rdata & 32'h0000_0019, 32'h0000_0009);
      wb(1'b1, `OPT_ADR_CTRL, 32'h0000_0000);
   endtask
   // Supply lost and restored while running: management and start-up again
   task t_replug;
      @(posedge clk_i);
      power_good_i <= 1'b0;
      wait_sig(3, 1'b0, 4);
      wait_sig(4, 1'b0, 4);
      wait_sig(0, 1'b0, 4);
      power_good_i <= 1'b1;
      wait_sig(3, 1'b1, T2W * MHZ);
      wait_sig(4, 1'b1, TST * MHZ);
      wb(1'b0, `OPT_ADR_IRQ_STAT, 32'h0000_0000);
      chk_word(rdata & 32'h0000_0010, 32'h0000_0010);
   endtask
   // Cycle ceiling against a hang
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("mismatch at %0t: cycle ceiling reached", $time);
         conclude;
      end
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      t_startup;
      t_disable;
      t_los_irq;
      t_rate;
      t_pl2;
      t_fault(1'b0);
      t_fault(1'b1);
      t_replug;
      conclude;
   end
endmodule
